// File: design/tws_pkg.sv
// Constants, field positions and carrier types of the two-wire serial channel.
// Assumes an 8-bit register port with a 16-bit address and one system clock.
package tws_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int BITS = 8;
  localparam int CNT_W = 4;

  localparam logic [15:0] ADDR_MODE = 16'hff60;
  localparam logic [15:0] ADDR_BUSCTL = 16'hff61;
  localparam logic [15:0] ADDR_TIMING = 16'hff62;
  localparam logic [15:0] ADDR_SHIFT = 16'hff63;
  localparam logic [15:0] ADDR_SVA = 16'hff64;
  localparam logic [15:0] ADDR_AUX = 16'hff65;

  localparam int MODE_ENABLE = 7;
  localparam int MODE_MATCH = 6;
  localparam int MODE_WUP = 5;
  localparam int MODE_BUS = 4;
  localparam int MODE_CLK_HIGH = 2;
  localparam int MODE_CLK_LOW = 1;

  localparam int BUSCTL_RELEASE_TRIGGER = 0;
  localparam int BUSCTL_COMMAND_TRIGGER = 1;
  localparam int BUSCTL_RELD = 2;
  localparam int BUSCTL_COMMAND_DETECT = 3;
  localparam int BUSCTL_KEEP_LO = 4;

  localparam int TIMING_CLD = 6;

  localparam int AUX_FLAG = 0;
  localparam int AUX_PORT_LATCH = 1;

  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_BUSCTL = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_SHIFT = 8'h00;
  localparam logic [7:0] RST_SVA = 8'h00;
  localparam logic RST_PORT_LATCH = 1'b1;
  localparam logic RST_OUT_LATCH = 1'b1;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef struct packed {
    logic enable;
    logic wake_up_control;
    logic [4:0] sel;
  } tws_mode_t;

  typedef struct packed {
    logic command_detect;
    logic reld;
    logic command_trigger;
    logic release_trigger;
  } tws_busflags_t;
endpackage

// File: design/tws_channel.sv
// Two-wire clocked serial channel: register port, shift engine, line drivers.
// Assumes all pin inputs are synchronous to i_ref_clk and the lines are pulled up.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Wake-up off: flag the interrupt after every finished transfer.
// - Wake-up on, bus modes: flag only when address after release matches.
// - Match flag at bit 6 shows shift equals slave address; zero when disabled.
// - Channel enable off stops transfers, triggers and pin drivers; registers stay writable; on permits operation.
// - Release trigger sets the output latch, then self-clears; cleared when disabled.
// - Command trigger clears the output latch, then self-clears; cleared when disabled.
// - Timing register bit 6 shows clock level; zero when disabled.
// - Eight-bit units; shift register moves on serial clock falling edges, the eighth bit on the last rising edge.
// - Output latch drives the selected data pin, most significant bit first.
// - Selected data pin is sampled on serial clock rising edges.
// - After the eighth bit shifting stops and the interrupt flag sets, subject to the wake-up rule above.
// - Internal clock mode: clock pin level gated by its port latch.
// - Shift write starts only when enabled and clock stopped or high.
// - Enabling after a shift write does not start a transfer.
// - Transmit captures the real line state into the shift register.
// - Clock select: external pin, timer output, or prescaled clock.
module tws_channel (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_timer_tick,
  input wire logic i_prescale_tick,
  input wire logic i_sck,
  output logic o_sck_out,
  output logic o_sck_oe,
  input wire logic i_data_a,
  output logic o_data_a_out,
  output logic o_data_a_oe,
  input wire logic i_data_b,
  output logic o_data_b_out,
  output logic o_data_b_oe,
  output logic o_channel_interrupt_flag
);
  tws_pkg::tws_mode_t mode, next_mode;
  tws_pkg::tws_busflags_t flags, next_flags;
  logic [3:0] busctl_hi, next_busctl_hi;
  logic [7:0] timing, next_timing;
  logic [7:0] shift, next_shift;
  logic [7:0] slave_address_register, next_sva;
  logic [7:0] rdata, next_rdata;
  logic [3:0] count, next_count;
  logic busy, next_busy;
  logic got_bit, next_got_bit;
  logic hold_bit, next_hold_bit;
  logic out_latch, next_out_latch;
  logic port_latch, next_port_latch;
  logic irq_flag, next_irq_flag;
  logic sck_int, next_sck_int;
  logic sck_prev, next_sck_prev;
  logic line_prev, next_line_prev;
  logic addr_pending, next_addr_pending;

  logic internal_clk;
  logic tick;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic pin_a_sel;
  logic line;
  logic match;
  logic bus_mode;
  logic clk_ok;
  logic wr_mode, wr_busctl, wr_timing, wr_shift, wr_sva, wr_aux;
  logic [7:0] mode_rd;

  always_comb begin
    internal_clk = mode.sel[tws_pkg::MODE_CLK_LOW];
    // Timer output or prescaled clock drives the internal clock
    tick = mode.sel[tws_pkg::MODE_CLK_HIGH] ? i_prescale_tick : i_timer_tick;
    // External clock comes from the pin, internal from the divider
    sck_lvl = internal_clk ? sck_int : i_sck;
    sck_rise = mode.enable && busy && sck_lvl && !sck_prev;
    sck_fall = mode.enable && busy && !sck_lvl && sck_prev;
    pin_a_sel = mode.sel[tws_pkg::MODE_CLK_HIGH];
    // Line read back is the real bus level, not the latch
    line = pin_a_sel ? i_data_a : i_data_b;
    match = mode.enable && (shift == slave_address_register);
    bus_mode = mode.sel[tws_pkg::MODE_BUS];
    // Internal clock stopped, or external clock high
    clk_ok = internal_clk ? !busy : (i_sck && !busy);
    wr_mode = i_wr && (i_addr == tws_pkg::ADDR_MODE);
    wr_busctl = i_wr && (i_addr == tws_pkg::ADDR_BUSCTL);
    wr_timing = i_wr && (i_addr == tws_pkg::ADDR_TIMING);
    wr_shift = i_wr && (i_addr == tws_pkg::ADDR_SHIFT);
    wr_sva = i_wr && (i_addr == tws_pkg::ADDR_SVA);
    wr_aux = i_wr && (i_addr == tws_pkg::ADDR_AUX);
    mode_rd = {mode.enable, match, mode.wake_up_control, mode.sel};
  end

  always_comb begin
    next_mode = mode;
    next_flags = flags;
    next_busctl_hi = busctl_hi;
    next_timing = timing;
    next_shift = shift;
    next_sva = slave_address_register;
    next_count = count;
    next_busy = busy;
    next_got_bit = got_bit;
    next_hold_bit = hold_bit;
    next_out_latch = out_latch;
    next_port_latch = port_latch;
    next_irq_flag = irq_flag;
    next_sck_int = sck_int;
    next_sck_prev = sck_lvl;
    next_line_prev = line;
    next_addr_pending = addr_pending;
    next_rdata = 8'h00;

    // Triggers act for one cycle only, then read back as zero
    next_flags.release_trigger = 1'b0;
    next_flags.command_trigger = 1'b0;

    if (wr_mode) begin
      next_mode = {i_wdata[tws_pkg::MODE_ENABLE], i_wdata[tws_pkg::MODE_WUP], i_wdata[4:0]};
    end
    if (wr_busctl) begin
      next_busctl_hi = i_wdata[7:4];
    end
    if (wr_timing) begin
      next_timing = i_wdata;
    end
    if (wr_sva) begin
      next_sva = i_wdata;
    end
    if (wr_aux) begin
      next_port_latch = i_wdata[tws_pkg::AUX_PORT_LATCH];
    end
    // Software clears the flag by writing one; a completing transfer still wins
    if (wr_aux && i_wdata[tws_pkg::AUX_FLAG]) begin
      next_irq_flag = 1'b0;
    end

    if (mode.enable) begin
      if (wr_busctl && i_wdata[tws_pkg::BUSCTL_RELEASE_TRIGGER]) begin
        next_flags.release_trigger = 1'b1;
        next_out_latch = 1'b1;
      end else if (wr_busctl && i_wdata[tws_pkg::BUSCTL_COMMAND_TRIGGER]) begin
        next_flags.command_trigger = 1'b1;
        next_out_latch = 1'b0;
      end

      // Data edges while the clock is high mark release and command
      if (sck_lvl && sck_prev && line && !line_prev) begin
        next_flags.reld = 1'b1;
        next_flags.command_detect = 1'b0;
        next_addr_pending = 1'b1;
      end else if (sck_lvl && sck_prev && !line && line_prev) begin
        next_flags.command_detect = 1'b1;
        next_flags.reld = 1'b0;
      end

      // A write while busy keeps the running byte intact
      if (wr_shift && !busy) begin
        next_shift = i_wdata;
        next_out_latch = i_wdata[7];
        if (clk_ok) begin
          next_busy = 1'b1;
          next_count = 4'h0;
          next_got_bit = 1'b0;
          next_sck_int = 1'b1;
        end
      end

      // Half a clock period per tick; stops high after the last rising edge
      if (busy && internal_clk && tick) begin
        next_sck_int = !sck_int;
      end

      if (sck_rise) begin
        if (count == tws_pkg::LAST_BIT) begin
          // No falling edge follows the eighth bit, so it lands now
          next_shift = {shift[6:0], line};
          next_busy = 1'b0;
          next_count = 4'h0;
          next_got_bit = 1'b0;
          next_sck_int = 1'b1;
          next_addr_pending = 1'b0;
          if (!mode.wake_up_control || !bus_mode) begin
            next_irq_flag = 1'b1;
          end else if (addr_pending && ({shift[6:0], line} == slave_address_register)) begin
            next_irq_flag = 1'b1;
          end
        end else begin
          next_hold_bit = line;
          next_got_bit = 1'b1;
        end
      end else if (sck_fall && got_bit) begin
        // The first falling edge only opens the frame
        next_shift = {shift[6:0], hold_bit};
        next_out_latch = shift[6];
        next_count = count + 4'h1;
        next_got_bit = 1'b0;
      end
    end else begin
      // Disabled channel: no transfer, triggers and detect flags cleared
      next_busy = 1'b0;
      next_count = 4'h0;
      next_got_bit = 1'b0;
      next_sck_int = 1'b1;
      next_flags = '0;
      next_addr_pending = 1'b0;
      if (wr_shift) begin
        next_shift = i_wdata;
      end
    end

    if (i_rd) begin
      unique case (i_addr)
        tws_pkg::ADDR_MODE: next_rdata = mode_rd;
        tws_pkg::ADDR_BUSCTL: next_rdata = {busctl_hi, flags};
        tws_pkg::ADDR_TIMING: begin
          next_rdata = timing;
          next_rdata[tws_pkg::TIMING_CLD] = mode.enable && sck_lvl;
        end
        tws_pkg::ADDR_SHIFT: next_rdata = shift;
        tws_pkg::ADDR_SVA: next_rdata = slave_address_register;
        tws_pkg::ADDR_AUX: next_rdata = {6'h00, port_latch, irq_flag};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode <= tws_pkg::RST_MODE[6:0];
      flags <= tws_pkg::RST_BUSCTL[3:0];
      busctl_hi <= tws_pkg::RST_BUSCTL[7:4];
      timing <= tws_pkg::RST_TIMING;
      shift <= tws_pkg::RST_SHIFT;
      slave_address_register <= tws_pkg::RST_SVA;
      rdata <= 8'h00;
      count <= 4'h0;
      busy <= 1'b0;
      got_bit <= 1'b0;
      hold_bit <= 1'b0;
      out_latch <= tws_pkg::RST_OUT_LATCH;
      port_latch <= tws_pkg::RST_PORT_LATCH;
      irq_flag <= 1'b0;
      sck_int <= 1'b1;
      sck_prev <= 1'b1;
      line_prev <= 1'b1;
      addr_pending <= 1'b0;
    end else begin
      mode <= next_mode;
      flags <= next_flags;
      busctl_hi <= next_busctl_hi;
      timing <= next_timing;
      shift <= next_shift;
      slave_address_register <= next_sva;
      rdata <= next_rdata;
      count <= next_count;
      busy <= next_busy;
      got_bit <= next_got_bit;
      hold_bit <= next_hold_bit;
      out_latch <= next_out_latch;
      port_latch <= next_port_latch;
      irq_flag <= next_irq_flag;
      sck_int <= next_sck_int;
      sck_prev <= next_sck_prev;
      line_prev <= next_line_prev;
      addr_pending <= next_addr_pending;
    end
  end

  // Open-drain pins only ever pull low; the pull-up gives the high level
  always_comb begin
    o_rdata = rdata;
    o_sck_out = 1'b0;
    o_sck_oe = mode.enable && internal_clk && !(sck_int && port_latch);
    o_data_a_out = 1'b0;
    o_data_b_out = 1'b0;
    o_data_a_oe = mode.enable && pin_a_sel && !out_latch;
    o_data_b_oe = mode.enable && !pin_a_sel && !out_latch;
    o_channel_interrupt_flag = irq_flag;
  end
endmodule

`default_nettype wire

// File: tb/tws_channel_asserts.sv
// Checker of the serial channel's port relations.
// Assumes internal serial clocks and a clock port latch kept at 1.
`timescale 1ns/10ps
`default_nettype none
module tws_channel_asserts (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_timer_tick,
  input wire logic i_prescale_tick,
  input wire logic i_sck,
  input wire logic o_sck_out,
  input wire logic o_sck_oe,
  input wire logic i_data_a,
  input wire logic o_data_a_out,
  input wire logic o_data_a_oe,
  input wire logic i_data_b,
  input wire logic o_data_b_out,
  input wire logic o_data_b_oe,
  input wire logic o_channel_interrupt_flag
);
  logic en, wake_up_control, sel_a, int_clk, oe_q;
  logic [3:0] falls;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Mode copy taken on the same edge as the design's, so no skew
  always_ff @(posedge i_ref_clk) begin
    oe_q <= o_sck_oe;
    if (i_sys_rst) begin
      {en, wake_up_control, sel_a, int_clk} <= 4'h0;
      falls <= 4'h0;
    end else begin
      if (i_wr && i_addr == tws_pkg::ADDR_MODE) begin
        {en, wake_up_control, sel_a, int_clk} <= {i_wdata[7], i_wdata[5], i_wdata[2:1]};
      end
      if (i_wr && i_addr == tws_pkg::ADDR_SHIFT) begin
        falls <= 4'h0;
      end else if (o_sck_oe && !oe_q) begin
        falls <= falls + 4'h1;
      end
    end
  end
  pin_a_sel_a: assert property (o_data_a_oe |-> en && sel_a)
    else $error("pin a driven unselected");
  pin_b_sel_a: assert property (o_data_b_oe |-> en && !sel_a)
    else $error("pin b driven unselected");
  match_off_a: assert property (
    $past(i_rd && !en && i_addr == tws_pkg::ADDR_MODE) |-> !o_rdata[6])
    else $error("match flag while disabled");
  trig_clear_a: assert property (
    $past(i_rd && i_addr == tws_pkg::ADDR_BUSCTL) && !$past(i_wr, 2) |-> o_rdata[1:0] == 2'b00)
    else $error("trigger bit not cleared");
  cmd_low_a: assert property (
    i_wr && en && sel_a && i_addr == tws_pkg::ADDR_BUSCTL && i_wdata[1:0] == 2'b10
    |=> o_data_a_oe) else $error("command trigger no low");
  rel_high_a: assert property (
    i_wr && en && sel_a && i_addr == tws_pkg::ADDR_BUSCTL && i_wdata[1:0] == 2'b01
    |=> !o_data_a_oe) else $error("release trigger no high");
  flag_hold_a: assert property (
    $fell(o_channel_interrupt_flag) && !$past(i_sys_rst)
    |-> $past(i_wr && i_wdata[0] && i_addr == tws_pkg::ADDR_AUX))
    else $error("flag dropped without clear");
  xfer_done_a: assert property (
    i_wr && en && int_clk && !wake_up_control && !o_channel_interrupt_flag
    && i_addr == tws_pkg::ADDR_SHIFT |-> ##[2:300] o_channel_interrupt_flag)
    else $error("transfer did not finish");
  eight_falls_a: assert property (
    $rose(o_channel_interrupt_flag) && int_clk |-> falls == 4'h8)
    else $error("clock fall count wrong");
endmodule

bind tws_channel tws_channel_asserts chk_u (.*);
`default_nettype wire

// File: tb/tws_peer.sv
// Partner: another open-drain talker on the data lines.
// Assumes the bench resolves the lines with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module tws_peer (
  input wire logic i_ref_clk,
  input wire logic i_sck_line,
  input wire logic i_load,
  input wire logic [7:0] i_byte,
  output logic o_data_oe
);
  logic [7:0] sh = 8'hff;
  logic [3:0] n = 4'h0;
  logic sck_q = 1'b1;
  logic act = 1'b0;
  // Only ever pulls low; released bits go to the pull-up level
  assign o_data_oe = act && !sh[7];
  always @(posedge i_ref_clk) begin
    sck_q <= i_sck_line;
    if (i_load) begin
      {sh, n, act} <= {i_byte, 4'h0, 1'b1};
    end else if (sck_q && !i_sck_line) begin
      n <= n + 4'h1;
      // First fall opens the frame, so the top bit stays put
      if (n != 4'h0) sh <= {sh[6:0], 1'b1};
    end else if (!sck_q && i_sck_line && n == 4'h8) begin
      act <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb/tws_channel_tb.sv
// Bench: register-level tests of the serial channel against a peer.
// Assumes pull-ups on the clock line and both data lines.
`timescale 1ns/10ps
`default_nettype none
module tws_channel_tb;
  logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_timer_tick = 1'b0, i_prescale_tick = 1'b0, p_load = 1'b0, sck_q = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00, p_byte = 8'hff, cap = 8'h00, mode = 8'h00, o_rdata;
  logic o_sck_out, o_sck_oe, o_data_a_out, o_data_a_oe, o_data_b_out, o_data_b_oe;
  logic o_channel_interrupt_flag, p_oe, i_sck, i_data_a, i_data_b;
  logic [2:0] tc = 3'h0;
  int errors = 0, n_tests = 0, cyc = 0;
  assign i_sck = !o_sck_oe;
  assign i_data_a = !(o_data_a_oe || p_oe);
  assign i_data_b = !(o_data_b_oe || p_oe);
  tws_channel dut_u (.*);
  tws_peer peer_u (.i_ref_clk(i_ref_clk), .i_sck_line(i_sck), .i_load(p_load),
    .i_byte(p_byte), .o_data_oe(p_oe));
  always #50 i_ref_clk = !i_ref_clk;
  always @(posedge i_ref_clk) begin
    tc <= tc + 3'h1;
    i_prescale_tick <= tc[1:0] == 2'h3;
    i_timer_tick <= tc == 3'h7;
    sck_q <= i_sck;
    // Bits on the wire at each clock rise; the first lands on top
    if (i_sck && !sck_q) cap <= {cap[6:0], mode[2] ? i_data_a : i_data_b};
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("tests=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    if (a == tws_pkg::ADDR_MODE) mode <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
    @(posedge i_ref_clk);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic [7:0] pb, input logic [7:0] exp,
    input logic [7:0] exp_mode);
    wr(tws_pkg::ADDR_AUX, 8'h03);
    {p_byte, p_load} <= {pb, 1'b1};
    @(posedge i_ref_clk);
    p_load <= 1'b0;
    wr(tws_pkg::ADDR_SHIFT, tx);
    for (int k = 0; k < 300 && o_channel_interrupt_flag !== 1'b1; k++) @(posedge i_ref_clk);
    chk(cap, exp);
    rd(tws_pkg::ADDR_SHIFT, exp);
    rd(tws_pkg::ADDR_MODE, exp_mode);
    rd(tws_pkg::ADDR_AUX, 8'h03);
  endtask
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    for (int i = 0; i < 7; i++) rd(tws_pkg::ADDR_MODE + 16'(i), (i == 5) ? 8'h02 : 8'h00);
    wr(tws_pkg::ADDR_BUSCTL, 8'h02);
    chk({6'h00, o_data_a_oe, o_data_b_oe}, 8'h00);
    wr(tws_pkg::ADDR_MODE, 8'h9e);
    wr(tws_pkg::ADDR_TIMING, 8'h00);
    wr(tws_pkg::ADDR_SVA, 8'ha5);
    rd(tws_pkg::ADDR_TIMING, 8'h40);
    rd(tws_pkg::ADDR_MODE, 8'h9e);
    wr(tws_pkg::ADDR_BUSCTL, 8'h02);
    chk({7'h00, o_data_a_oe}, 8'h01);
    rd(tws_pkg::ADDR_BUSCTL, 8'h08);
    wr(tws_pkg::ADDR_BUSCTL, 8'h01);
    chk({7'h00, o_data_a_oe}, 8'h00);
    xfer(8'ha5, 8'hff, 8'ha5, 8'hde);
    xfer(8'ha5, 8'h0f, 8'h05, 8'h9e);
    wr(tws_pkg::ADDR_MODE, 8'h9a);
    xfer(8'hff, 8'h3c, 8'h3c, 8'h9a);
    wr(tws_pkg::ADDR_SVA, 8'h3c);
    rd(tws_pkg::ADDR_MODE, 8'hda);
    // Wake-up on: only an address after a release that matches raises the flag
    wr(tws_pkg::ADDR_MODE, 8'hbe);
    wr(tws_pkg::ADDR_BUSCTL, 8'h02);
    wr(tws_pkg::ADDR_BUSCTL, 8'h01);
    xfer(8'h3c, 8'hff, 8'h3c, 8'hfe);
    wr(tws_pkg::ADDR_AUX, 8'h03);
    wr(tws_pkg::ADDR_SHIFT, 8'h3c);
    repeat (90) @(posedge i_ref_clk);
    rd(tws_pkg::ADDR_AUX, 8'h02);
    wr(tws_pkg::ADDR_MODE, 8'h1e);
    rd(tws_pkg::ADDR_MODE, 8'h1e);
    rd(tws_pkg::ADDR_TIMING, 8'h00);
    wr(tws_pkg::ADDR_AUX, 8'h03);
    wr(tws_pkg::ADDR_SHIFT, 8'h55);
    wr(tws_pkg::ADDR_MODE, 8'h9e);
    repeat (40) @(posedge i_ref_clk);
    rd(tws_pkg::ADDR_AUX, 8'h02);
    rd(tws_pkg::ADDR_SHIFT, 8'h55);
    summarize();
  end
endmodule
`default_nettype wire
